// ### core/pbt_bridge_top.sv
// Transaction limiter of a PCI bridge: single-phase I/O and config, flow-through, REQ64 retry, system error
//
// Operation
// - I/O and config cycles move one phase
// - Burst I/O or config read or write gets stop
// - Flow-through starts once second cacheline held, when the cap is above two lines
// - Zero prefetch factors cap at two lines
// - Retried read keeps first REQ64 level
// - No system error for upper-half split parity
`timescale 1ns/1ps
module pbt_bridge_top (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Secondary link, on its own clock
    input wire logic i_link_clk,
    input wire logic i_lk_valid,
    input wire logic i_lk_first,
    input wire logic i_lk_last,
    input wire logic [3:0] i_lk_cmd,
    input wire logic [31:0] i_lk_data,
    output logic o_lk_trdy,
    output logic o_lk_stop,
    // Forwarded words toward the primary side
    output logic o_fwd_valid,
    output logic [35:0] o_fwd_data,
    input wire logic i_fwd_ready,
    // Delayed read prefetch
    input wire logic [2:0] i_first_factor,
    input wire logic [2:0] i_reread_factor,
    input wire logic i_rd_start,
    input wire logic i_rd_reread,
    input wire logic i_rd_line,
    input wire logic i_rd_end,
    output logic o_fetch_more,
    output logic o_flow_through,
    output logic [4:0] o_prefetch_lines,
    // Memory read retry on the conventional side
    input wire logic i_mr_issue,
    input wire logic i_mr_want64,
    input wire logic i_mr_retried,
    input wire logic i_mr_done,
    output logic o_req64,
    // Parity error reporting
    input wire logic i_perr_lower,
    input wire logic i_perr_upper,
    input wire logic i_split_rd_phase,
    output logic o_primary_system_error_n
);
    // ----------------------------------------------------------------
    // Link domain
    // ----------------------------------------------------------------
    logic ce_lk_meta;
    logic ce_lk;
    logic ack_meta;
    logic ack_lk;
    logic lk_req;
    logic [pbt_pkg::XFER_W-1:0] lk_hold;
    logic lk_cut;
    logic lk_busy;
    logic lk_single;
    logic lk_take;
    logic cr_seen;

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ce_lk_meta <= 1'b0;
            ce_lk <= 1'b0;
            ack_meta <= 1'b0;
            ack_lk <= 1'b0;
        end else begin
            ce_lk_meta <= i_ce;
            ce_lk <= ce_lk_meta;
            ack_meta <= cr_seen;
            ack_lk <= ack_meta;
        end
    end

    assign lk_busy = (lk_req != ack_lk);
    assign lk_single = pbt_pkg::pbt_single_only(i_lk_cmd);
    // Only the first phase of an I/O or config cycle is ever taken
    assign lk_take = i_lk_valid && ce_lk && !lk_busy && !lk_cut;
    assign o_lk_trdy = lk_take;
    // Burst I/O or config: stop with the first phase, then disconnect without data
    assign o_lk_stop = i_lk_valid && ((lk_single && i_lk_first && !i_lk_last) || lk_cut);

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lk_cut <= 1'b0;
        end else if (ce_lk && i_lk_valid) begin
            if (i_lk_last) begin
                lk_cut <= 1'b0;
            end else if (lk_take && lk_single && i_lk_first) begin
                lk_cut <= 1'b1;
            end
        end
    end

    // Hold word stays still until the core domain hands back the toggle
    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lk_req <= 1'b0;
            lk_hold <= '0;
        end else if (lk_take) begin
            lk_req <= ~lk_req;
            lk_hold <= {i_lk_cmd, i_lk_data};
        end
    end

    a_burst_gets_stop: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
        lk_take && lk_single && i_lk_first && !i_lk_last |-> o_lk_stop)
        else $error("burst I/O or config phase taken without stop");

    sequence s_burst_first;
        lk_take && lk_single && i_lk_first && !i_lk_last;
    endsequence
    a_single_phase: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
        s_burst_first |=> !o_lk_trdy && (o_lk_stop || !i_lk_valid))
        else $error("second data phase of I/O or config burst taken");

    // ----------------------------------------------------------------
    // Core domain: word crossing into the FIFO
    // ----------------------------------------------------------------
    logic req_meta;
    logic req_cr;

    pbt_fifo_if #(.W(pbt_pkg::XFER_W)) fq ();

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            req_meta <= 1'b0;
            req_cr <= 1'b0;
        end else begin
            req_meta <= lk_req;
            req_cr <= req_meta;
        end
    end

    assign fq.wr_valid = (req_cr != cr_seen);
    assign fq.wr_data = lk_hold;
    assign fq.rd_ready = i_fwd_ready;
    assign o_fwd_valid = fq.rd_valid;
    assign o_fwd_data = fq.rd_data;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cr_seen <= 1'b0;
        end else if (i_ce && fq.wr_valid && fq.wr_ready) begin
            cr_seen <= req_cr;
        end
    end

    pbt_fifo #(.W(pbt_pkg::XFER_W), .D(pbt_pkg::FIFO_DEPTH)) u_fifo (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .f(fq)
    );

    // ----------------------------------------------------------------
    // Delayed read prefetch and flow-through
    // ----------------------------------------------------------------
    logic rd_active;
    logic [pbt_pkg::LINES_W-1:0] held;
    logic [pbt_pkg::FACTOR_W-1:0] factor_sel;

    assign factor_sel = i_rd_reread ? i_reread_factor : i_first_factor;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_active <= 1'b0;
            held <= '0;
            o_prefetch_lines <= pbt_pkg::LINES_MIN;
        end else if (i_ce) begin
            if (i_rd_start) begin
                rd_active <= 1'b1;
                held <= '0;
                o_prefetch_lines <= pbt_pkg::pbt_prefetch_limit(factor_sel);
            end else if (i_rd_end) begin
                rd_active <= 1'b0;
            end else if (rd_active && i_rd_line && (held < o_prefetch_lines)) begin
                held <= pbt_pkg::LINES_W'(held + 1'b1);
            end
        end
    end

    assign o_fetch_more = rd_active && (held < o_prefetch_lines);
    // A two-line cap never lets delivery overlap fetching
    assign o_flow_through = rd_active && (held >= pbt_pkg::FLOW_LINE) &&
                            (o_prefetch_lines > pbt_pkg::LINES_MIN);

    a_flow_enter: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        i_ce && rd_active && !i_rd_start && !i_rd_end && i_rd_line &&
        (held == pbt_pkg::FLOW_LINE - 1) && (o_prefetch_lines > pbt_pkg::LINES_MIN)
        |=> o_flow_through)
        else $error("flow-through not entered at second cacheline");
    a_zero_cap: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        i_ce && i_rd_start && (factor_sel == pbt_pkg::FACTOR_ZERO)
        |=> (o_prefetch_lines == pbt_pkg::LINES_MIN) && !o_flow_through)
        else $error("zero prefetch factors did not cap at two lines");
    a_line_cap: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        held <= o_prefetch_lines)
        else $error("more lines held than prefetch limit");

    // ----------------------------------------------------------------
    // REQ64 level kept across retries
    // ----------------------------------------------------------------
    pbt_pkg::pbt_req_state_t rq_state;
    pbt_pkg::pbt_req_state_t next_rq_state;
    logic req64_first;

    always_comb begin
        next_rq_state = rq_state;
        case (rq_state)
            pbt_pkg::PBT_RQ_IDLE: begin
                if (i_mr_issue) begin
                    next_rq_state = pbt_pkg::PBT_RQ_FIRST;
                end
            end
            pbt_pkg::PBT_RQ_FIRST, pbt_pkg::PBT_RQ_RETRY: begin
                if (i_mr_done) begin
                    next_rq_state = pbt_pkg::PBT_RQ_IDLE;
                end else if (i_mr_retried) begin
                    next_rq_state = pbt_pkg::PBT_RQ_RETRY;
                end
            end
            default: begin
                next_rq_state = pbt_pkg::PBT_RQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rq_state <= pbt_pkg::PBT_RQ_IDLE;
        end else if (i_ce) begin
            rq_state <= next_rq_state;
        end
    end

    // Width is frozen at the first attempt; later wishes are ignored
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            req64_first <= 1'b0;
        end else if (i_ce && (rq_state == pbt_pkg::PBT_RQ_IDLE) && i_mr_issue) begin
            req64_first <= i_mr_want64;
        end
    end

    assign o_req64 = (rq_state == pbt_pkg::PBT_RQ_IDLE) ? i_mr_want64 : req64_first;

    sequence s_read_retried;
        (rq_state == pbt_pkg::PBT_RQ_IDLE) && i_mr_issue && i_ce
        ##3 (rq_state == pbt_pkg::PBT_RQ_RETRY) && i_mr_issue;
    endsequence
    a_req64_stable: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        s_read_retried |-> o_req64 == $past(o_req64, 3))
        else $error("REQ64 level changed on retried read");

    // ----------------------------------------------------------------
    // Primary system error
    // ----------------------------------------------------------------
    logic serr_hit;

    // Upper half of a split read response carries no data
    assign serr_hit = i_perr_lower || (i_perr_upper && !i_split_rd_phase);

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_primary_system_error_n <= 1'b1;
        end else if (i_ce) begin
            o_primary_system_error_n <= !serr_hit;
        end
    end

    a_serr_upper_split: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        i_ce && i_perr_upper && i_split_rd_phase && !i_perr_lower |=> o_primary_system_error_n)
        else $error("system error raised for upper-half split response parity");
    a_serr_lower: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        i_ce && i_perr_lower |=> !o_primary_system_error_n ##1 (o_primary_system_error_n || $past(serr_hit)))
        else $error("system error missing for lower-half parity error");
endmodule // pbt_bridge_top

// ### core/pbt_pkg.sv
// Shared constants, types and decode helpers for the bridge transaction limiter
package pbt_pkg;
    // ----------------------------------------------------------------
    // Bus command codes
    // ----------------------------------------------------------------
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    // ----------------------------------------------------------------
    // Widths and sizes
    // ----------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int CMD_W = 4;
    localparam int XFER_W = CMD_W + DATA_W;
    localparam int FIFO_DEPTH = 4;
    localparam int FACTOR_W = 3;
    localparam int LINES_W = 5;
    localparam logic [LINES_W-1:0] LINES_MIN = 5'h02;
    localparam logic [LINES_W-1:0] FLOW_LINE = 5'h02;
    localparam logic [FACTOR_W-1:0] FACTOR_ZERO = 3'h0;

    typedef enum logic [1:0] {
        PBT_RQ_IDLE = 2'b00,
        PBT_RQ_FIRST = 2'b01,
        PBT_RQ_RETRY = 2'b10
    } pbt_req_state_t;

    // I/O and configuration cycles only ever move one data phase
    function automatic logic pbt_single_only(input logic [3:0] cmd);
        pbt_single_only = (cmd == CMD_IO_RD) || (cmd == CMD_IO_WR) ||
                          (cmd == CMD_CFG_RD) || (cmd == CMD_CFG_WR);
    endfunction

    function automatic logic [LINES_W-1:0] pbt_prefetch_limit(input logic [FACTOR_W-1:0] f);
        pbt_prefetch_limit = LINES_MIN + {1'b0, f, 1'b0};
    endfunction
endpackage

// ### core/pbt_fifo_if.sv
// Valid/ready carrier between the bridge core and its word FIFO
`timescale 1ns/1ps
interface pbt_fifo_if #(parameter int W = 36);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    modport src (output wr_valid, output wr_data, input wr_ready,
                 input rd_valid, input rd_data, output rd_ready);
    modport fifo (input wr_valid, input wr_data, output wr_ready,
                  output rd_valid, output rd_data, input rd_ready);
endinterface

// ### core/pbt_fifo.sv
// Shift-register FIFO whose head word always sits in a flop
`timescale 1ns/1ps
module pbt_fifo #(
    parameter int W = 36,
    parameter int D = 4
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    pbt_fifo_if.fifo f
);
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [CW-1:0] CNT_FULL = CW'(D);

    logic [W-1:0] slot [D];
    logic [CW-1:0] count;
    logic push;
    logic pop;

    assign f.wr_ready = (count != CNT_FULL);
    assign f.rd_valid = (count != '0);
    assign f.rd_data = slot[0];
    assign push = f.wr_valid && f.wr_ready;
    assign pop = f.rd_valid && f.rd_ready;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            count <= '0;
        end else if (i_ce) begin
            count <= CW'(count + CW'(push) - CW'(pop));
        end
    end

    // ----------------------------------------------------------------
    // Storage: shift down on pop, write behind the last live word
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < D; g++) begin : g_slot
            always_ff @(posedge i_mclk or negedge i_rstn) begin
                if (!i_rstn) begin
                    slot[g] <= '0;
                end else if (i_ce) begin
                    if (push && (CW'(g) == (pop ? CW'(count - CNT_ONE) : count))) begin
                        slot[g] <= f.wr_data;
                    end else if (pop && (g < D - 1)) begin
                        slot[g] <= slot[(g < D - 1) ? g + 1 : g];
                    end
                end
            end
        end
    endgenerate

    a_fifo_no_overrun: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        i_ce && (count == CNT_FULL) && !pop |=> count == CNT_FULL)
        else $error("fifo count moved past full");
endmodule // pbt_fifo

// ### verif/pbt_link_init.sv
// Link-side initiator model that offers data phases to the bridge
`timescale 1ns/1ps
module pbt_link_init (
    input wire logic i_link_clk,
    input wire logic i_trdy,
    input wire logic i_stop,
    output logic o_valid,
    output logic o_first,
    output logic o_last,
    output logic [3:0] o_cmd,
    output logic [31:0] o_data
);
    initial begin
        o_valid = 1'b0;
        o_first = 1'b0;
        o_last = 1'b0;
        o_cmd = 4'h0;
        o_data = 32'h0;
    end

    // ------------------------------------------------------------
    // One data phase, held until the target answers or 40 link clocks pass
    // ------------------------------------------------------------
    // Every phase is one aligned 32-bit word; the link has no wider path
    task automatic phase(input logic first, input logic last, input logic [3:0] cmd,
                         input logic [31:0] data, output logic took, output logic stp);
        int n;
        took = 1'b0;
        stp = 1'b0;
        @(posedge i_link_clk);
        o_valid <= 1'b1;
        o_first <= first;
        o_last <= last;
        o_cmd <= cmd;
        o_data <= data;
        for (n = 0; n < 40; n++) begin
            // Answer is combinational, so look before the taking edge
            @(negedge i_link_clk);
            if (i_trdy === 1'b1 || i_stop === 1'b1) begin
                took = i_trdy;
                stp = i_stop;
                n = 40;
            end
            @(posedge i_link_clk);
        end
        o_valid <= 1'b0;
        // Released data must not look like the last word
        o_data <= ~data;
    endtask
endmodule // pbt_link_init

// ### verif/pci_bridge_transaction_limits_bench.sv
// Self-checking bench for the bridge transaction limiter
`timescale 1ns/1ps
module pci_bridge_transaction_limits_bench;
    logic i_mclk, i_rstn, i_ce, i_link_clk, lk_valid, lk_first, lk_last, o_lk_trdy, o_lk_stop;
    logic [3:0] lk_cmd;
    logic [31:0] lk_data;
    logic o_fwd_valid, i_fwd_ready, i_rd_start, i_rd_reread, i_rd_line, i_rd_end, o_fetch_more, o_flow_through;
    logic [35:0] o_fwd_data;
    logic [2:0] i_first_factor, i_reread_factor;
    logic [4:0] o_prefetch_lines;
    logic i_mr_issue, i_mr_want64, i_mr_retried, i_mr_done, o_req64;
    logic i_perr_lower, i_perr_upper, i_split_rd_phase, o_primary_system_error_n;
    logic [3:0] cmds [4] = '{pbt_pkg::CMD_IO_RD, pbt_pkg::CMD_IO_WR, pbt_pkg::CMD_CFG_RD, pbt_pkg::CMD_CFG_WR};
    int n_mismatch = 0;
    int checks_done = 0;

    pbt_bridge_top dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce), .i_link_clk(i_link_clk),
        .i_lk_valid(lk_valid), .i_lk_first(lk_first), .i_lk_last(lk_last), .i_lk_cmd(lk_cmd),
        .i_lk_data(lk_data), .o_lk_trdy(o_lk_trdy), .o_lk_stop(o_lk_stop), .o_fwd_valid(o_fwd_valid),
        .o_fwd_data(o_fwd_data), .i_fwd_ready(i_fwd_ready), .i_first_factor(i_first_factor),
        .i_reread_factor(i_reread_factor), .i_rd_start(i_rd_start), .i_rd_reread(i_rd_reread),
        .i_rd_line(i_rd_line), .i_rd_end(i_rd_end), .o_fetch_more(o_fetch_more),
        .o_flow_through(o_flow_through), .o_prefetch_lines(o_prefetch_lines), .i_mr_issue(i_mr_issue),
        .i_mr_want64(i_mr_want64), .i_mr_retried(i_mr_retried), .i_mr_done(i_mr_done), .o_req64(o_req64),
        .i_perr_lower(i_perr_lower), .i_perr_upper(i_perr_upper), .i_split_rd_phase(i_split_rd_phase),
        .o_primary_system_error_n(o_primary_system_error_n));

    pbt_link_init init_u (.i_link_clk(i_link_clk), .i_trdy(o_lk_trdy), .i_stop(o_lk_stop), .o_valid(lk_valid),
        .o_first(lk_first), .o_last(lk_last), .o_cmd(lk_cmd), .o_data(lk_data));

    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    initial begin
        i_link_clk = 1'b0;
        #7;
        forever #32 i_link_clk = ~i_link_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Checks made: %0d, mismatches: %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Waits for the head word, compares it, then pops it with a one-cycle ready
    task automatic pop(input logic [35:0] exp);
        int n;
        for (n = 0; n < 50; n++) begin
            @(negedge i_mclk);
            if (o_fwd_valid === 1'b1) break;
        end
        check("fwd_valid", 36'(o_fwd_valid), 36'h1);
        check("fwd_data", o_fwd_data, exp);
        @(posedge i_mclk);
        i_fwd_ready <= 1'b1;
        @(posedge i_mclk);
        i_fwd_ready <= 1'b0;
    endtask

    task automatic no_word();
        repeat (12) @(posedge i_mclk);
        @(negedge i_mclk);
        check("fwd_empty", 36'(o_fwd_valid), 36'h0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_single();
        logic took, stp;
        foreach (cmds[k]) begin
            init_u.phase(1'b1, 1'b1, cmds[k], 32'h5A5A0000 + 32'(k), took, stp);
            check("single_trdy", 36'(took), 36'h1);
            check("single_stop", 36'(stp), 36'h0);
            pop({cmds[k], 32'h5A5A0000 + 32'(k)});
        end
    endtask

    // Every phase after the first is stopped and dropped, last one included
    task automatic t_burst();
        logic took, stp;
        foreach (cmds[k]) begin
            init_u.phase(1'b1, 1'b0, cmds[k], 32'hB0B00000 + 32'(k), took, stp);
            check("burst_first", {34'h0, took, stp}, 36'h3);
            init_u.phase(1'b0, 1'b0, cmds[k], 32'hDEAD0001, took, stp);
            check("burst_mid", {34'h0, took, stp}, 36'h1);
            init_u.phase(1'b0, 1'b1, cmds[k], 32'hDEAD0002, took, stp);
            check("burst_last", {34'h0, took, stp}, 36'h1);
            pop({cmds[k], 32'hB0B00000 + 32'(k)});
            no_word();
        end
    endtask

    // Drain held off: four words fit, a fifth waits in the hold word, the sixth is refused
    task automatic t_fill();
        logic took, stp;
        for (int k = 0; k < 6; k++) begin
            init_u.phase(1'b1, 1'b1, pbt_pkg::CMD_IO_WR, 32'hF1F00000 + 32'(k), took, stp);
            check("fill_trdy", 36'(took), (k < 5) ? 36'h1 : 36'h0);
        end
        for (int k = 0; k < 5; k++) pop({pbt_pkg::CMD_IO_WR, 32'hF1F00000 + 32'(k)});
        no_word();
    endtask

    // The factor not selected is set to 7 so a wrong pick shows in the limit
    task automatic t_prefetch(input logic reread, input logic [2:0] f);
        @(posedge i_mclk);
        i_first_factor <= reread ? 3'h7 : f;
        i_reread_factor <= reread ? f : 3'h7;
        i_rd_reread <= reread;
        i_rd_start <= 1'b1;
        @(posedge i_mclk);
        i_rd_start <= 1'b0;
        i_rd_reread <= 1'b0;
        @(negedge i_mclk);
        check("prefetch_lines", 36'(o_prefetch_lines), 36'(5'h02 + {1'b0, f, 1'b0}));
        for (int k = 1; k <= 2; k++) begin
            @(posedge i_mclk);
            i_rd_line <= 1'b1;
            @(posedge i_mclk);
            i_rd_line <= 1'b0;
            @(posedge i_mclk);
            @(negedge i_mclk);
            check("flow_through", 36'(o_flow_through), 36'(k == 2 && f != 3'h0));
            check("fetch_more", 36'(o_fetch_more), 36'(k == 1 || f != 3'h0));
        end
        @(posedge i_mclk);
        i_rd_end <= 1'b1;
        @(posedge i_mclk);
        i_rd_end <= 1'b0;
        @(negedge i_mclk);
        check("flow_after_end", 36'(o_flow_through), 36'h0);
    endtask

    // Width wish flips after the first attempt; the retry must not follow it
    task automatic t_req64(input logic w);
        @(posedge i_mclk);
        i_mr_want64 <= w;
        i_mr_issue <= 1'b1;
        @(posedge i_mclk);
        i_mr_issue <= 1'b0;
        i_mr_want64 <= ~w;
        @(negedge i_mclk);
        check("req64_first", 36'(o_req64), 36'(w));
        @(posedge i_mclk);
        i_mr_retried <= 1'b1;
        @(posedge i_mclk);
        i_mr_retried <= 1'b0;
        i_mr_issue <= 1'b1;
        @(posedge i_mclk);
        i_mr_issue <= 1'b0;
        @(negedge i_mclk);
        check("req64_retry", 36'(o_req64), 36'(w));
        @(posedge i_mclk);
        i_mr_done <= 1'b1;
        @(posedge i_mclk);
        i_mr_done <= 1'b0;
        @(negedge i_mclk);
        check("req64_idle", 36'(o_req64), 36'(!w));
    endtask

    task automatic t_serr(input logic lower, input logic upper, input logic split, input logic low);
        @(posedge i_mclk);
        i_perr_lower <= lower;
        i_perr_upper <= upper;
        i_split_rd_phase <= split;
        @(posedge i_mclk);
        i_perr_lower <= 1'b0;
        i_perr_upper <= 1'b0;
        @(negedge i_mclk);
        check("serr_n", 36'(o_primary_system_error_n), 36'(!low));
        @(negedge i_mclk);
        check("serr_n_after", 36'(o_primary_system_error_n), 36'h1);
    endtask

    // Enable low: a start and an error must leave the state untouched
    task automatic t_hold();
        @(posedge i_mclk);
        i_ce <= 1'b0;
        i_first_factor <= 3'h7;
        i_rd_start <= 1'b1;
        i_perr_lower <= 1'b1;
        @(posedge i_mclk);
        i_rd_start <= 1'b0;
        i_perr_lower <= 1'b0;
        @(negedge i_mclk);
        check("hold_lines", 36'(o_prefetch_lines), 36'h08);
        check("hold_serr_n", 36'(o_primary_system_error_n), 36'h1);
        @(posedge i_mclk);
        i_ce <= 1'b1;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        i_rstn = 1'b0;
        i_ce = 1'b1;
        i_fwd_ready = 1'b0;
        i_first_factor = 3'h0;
        i_reread_factor = 3'h0;
        {i_rd_start, i_rd_reread, i_rd_line, i_rd_end} = 4'h0;
        {i_mr_issue, i_mr_want64, i_mr_retried, i_mr_done} = 4'h0;
        {i_perr_lower, i_perr_upper, i_split_rd_phase} = 3'h0;
        repeat (4) @(posedge i_mclk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_mclk);
        @(negedge i_mclk);
        check("reset_lines", 36'(o_prefetch_lines), 36'h2);
        check("reset_serr_n", 36'(o_primary_system_error_n), 36'h1);
        t_single();
        t_burst();
        t_fill();
        t_prefetch(1'b0, 3'h0);
        t_prefetch(1'b1, 3'h0);
        t_prefetch(1'b0, 3'h1);
        t_prefetch(1'b1, 3'h3);
        t_hold();
        t_req64(1'b0);
        t_req64(1'b1);
        t_serr(1'b0, 1'b1, 1'b1, 1'b0);
        t_serr(1'b1, 1'b0, 1'b1, 1'b1);
        t_serr(1'b0, 1'b1, 1'b0, 1'b1);
        t_serr(1'b1, 1'b1, 1'b1, 1'b1);
        summarize();
    end

    // Whole run needs well under 100 us
    initial begin
        #500000;
        n_mismatch++;
        summarize();
    end
endmodule // pci_bridge_transaction_limits_bench
